// [verilog/usr_pkg.sv]
// Shared constants and carrier types for the synchronous slave receiver
`default_nettype none
package usr_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] OFF_IRQ_FLAGS_1 = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLES_1 = 8'h08;
  localparam logic [7:0] OFF_IRQ_PRIORITY_1 = 8'h0C;
  localparam logic [7:0] OFF_RECEIVE_STATUS_CONTROL = 8'h10;
  localparam logic [7:0] OFF_RECEIVE_BUFFER = 8'h14;
  localparam logic [7:0] OFF_TRANSMIT_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] OFF_BAUD_CONTROL = 8'h1C;
  localparam logic [7:0] OFF_BAUD_DIVISOR_HIGH = 8'h20;
  localparam logic [7:0] OFF_BAUD_DIVISOR_LOW = 8'h24;
  // interrupt_control fields
  localparam int GLOBAL_IRQ_ENABLE_POS = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_POS = 6;
  // Flags, enables and priority share one layout
  localparam int RX_IRQ_POS = 5;
  // receive_status_control fields
  localparam int PORT_ENABLE_POS = 7;
  localparam int NINE_BIT_RX_OPTION_POS = 6;
  localparam int SINGLE_RX_ENABLE_POS = 5;
  localparam int CONTINUOUS_RX_ENABLE_POS = 4;
  localparam int ADDRESS_DETECT_POS = 3;
  localparam int FRAMING_ERROR_FLAG_POS = 2;
  localparam int OVERRUN_ERROR_FLAG_POS = 1;
  localparam int NINTH_RX_BIT_POS = 0;
  localparam logic [7:0] RECEIVE_STATUS_CONTROL_WMASK = 8'hF8;
  // transmit_status_control fields
  localparam int CLOCK_SOURCE_SELECT_POS = 7;
  localparam int SYNC_MODE_POS = 4;
  // baud_control fields
  localparam int RX_IDLE_POS = 6;
  localparam int CLOCK_POLARITY_POS = 4;
  localparam logic [7:0] BAUD_CONTROL_WMASK = 8'h3B;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_BAUD_CONTROL = 8'h40;
  // Word sizes
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Link pins as one carrier
  typedef struct packed {
    logic ck;
    logic dt;
  } usr_link_t;

  // Word handed from the shifter
  typedef struct packed {
    logic done;
    logic busy;
    logic [8:0] word;
  } usr_word_t;
endpackage
`default_nettype wire

// [verilog/usr_sync2.sv]
// Two-flop synchroniser for the link pins
`timescale 1ns/1ns
`default_nettype none
module usr_sync2
  import usr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pins in, synchronised out
  input wire usr_link_t pin_in,
  output usr_link_t pin_out
);
  typedef struct packed {
    usr_link_t meta;
    usr_link_t stable;
  } usr_sync_st_t;

  usr_sync_st_t st_r;
  usr_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pin_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_out = st_r.stable;
endmodule // usr_sync2
`default_nettype wire

// [verilog/usr_shift.sv]
// Receive shift register: collects 8 or 9 bits, least significant first
`timescale 1ns/1ns
`default_nettype none
module usr_shift
  import usr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic clr,
  input wire logic smp,
  input wire logic din,
  input wire logic nine,
  // Result
  output usr_word_t res
);
  typedef struct packed {
    logic [3:0] cnt;
    logic [8:0] sr;
    logic done;
    logic [8:0] word;
  } usr_shift_st_t;

  usr_shift_st_t st_r;
  usr_shift_st_t st_nxt;
  logic [3:0] last;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    last = nine ? LAST_BIT_9 : LAST_BIT_8;
    if (clr) begin
      st_nxt.cnt = 4'h0;
    end else if (smp) begin
      st_nxt.sr[st_r.cnt] = din;
      if (st_r.cnt >= last) begin
        st_nxt.cnt = 4'h0;
        st_nxt.done = 1'b1;
        st_nxt.word = st_nxt.sr;
        if (!nine) begin
          st_nxt.word[8] = 1'b0;
        end
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res.done = st_r.done;
  assign res.busy = (st_r.cnt != 4'h0);
  assign res.word = st_r.word;
endmodule // usr_shift
`default_nettype wire

// [verilog/usr_rx_top.sv]
// Synchronous slave receiver with AXI4-Lite registers
// Overview of operation
// - Slave receive matches master receive; single-receive enable is ignored.
// - Reception continues and completes words during sleep or idle.
// - A finished word moves from shift register into the receive buffer.
// - Enabled receive interrupt wakes the device; global enable adds vectoring.
// - Slave receiver active when sync mode and port enable set, clock source clear.
// - Nine-bit option receives nine bits; ninth lands in receive status.
// - Words are accepted only while continuous receive enable is set.
// - Flag set on word completion; request raised only if enable set.
// - Software reads the low eight bits through the receive buffer.
// - Clearing continuous receive enable clears pending receive errors.
// - Interrupt reaches processor only with global and peripheral enables set.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module usr_rx_top
  import usr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link from the external master
  input wire logic link_ck,
  input wire logic link_dt,
  // Power state and interrupt lines
  input wire logic low_power,
  output logic irq,
  output logic irq_high_priority,
  output logic wake
);
  typedef struct packed {
    logic [7:0] interrupt_control;
    logic [7:0] irq_flags;
    logic [7:0] irq_enables;
    logic [7:0] irq_priority;
    logic [7:0] receive_status_control;
    logic [7:0] receive_buffer;
    logic [7:0] transmit_status_control;
    logic [7:0] baud_control;
    logic [7:0] baud_divisor_high;
    logic [7:0] baud_divisor_low;
    logic ck_prev;
    logic aw_ok;
    logic aw_hit;
    logic [7:0] aw_off;
    logic w_ok;
    logic [7:0] w_dat;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic irq_hp;
    logic wake;
  } usr_top_st_t;

  usr_top_st_t st_r;
  usr_top_st_t st_nxt;
  usr_link_t link_raw;
  usr_link_t link_s;
  usr_word_t rx;
  logic rx_active;
  logic smp;
  logic ck_rise;
  logic ck_fall;
  logic nine;
  logic rd_hit;
  logic [7:0] rd_val;
  logic [7:0] pend;
  logic sync_mode;
  logic port_on;
  logic clk_from_master;
  logic cont_enable;
  logic halted;
  logic wr_fire;
  logic rd_fire;
  // Receiver condition, as software sees it through the idle bit
  typedef enum logic [1:0] {
    RXS_OFF = 2'b00,
    RXS_IDLE = 2'b01,
    RXS_SHIFT = 2'b10,
    RXS_HALT = 2'b11
  } usr_rx_cond_t;
  usr_rx_cond_t rx_cond;

  assign link_raw.ck = link_ck;
  assign link_raw.dt = link_dt;

  // Pins cross into clk before anything looks at them
  usr_sync2 u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in(link_raw),
    .pin_out(link_s)
  );

  usr_shift u_shift (
    .clk(clk),
    .nrst(nrst),
    .clr(!rx_active),
    .smp(smp),
    .din(link_s.dt),
    .nine(nine),
    .res(rx)
  );

  // Mode decode; single-receive enable takes no part here
  assign sync_mode = st_r.transmit_status_control[SYNC_MODE_POS];
  assign port_on = st_r.receive_status_control[PORT_ENABLE_POS];
  assign clk_from_master = !st_r.transmit_status_control[CLOCK_SOURCE_SELECT_POS];
  assign cont_enable = st_r.receive_status_control[CONTINUOUS_RX_ENABLE_POS];
  assign halted = st_r.receive_status_control[OVERRUN_ERROR_FLAG_POS];

  always_comb begin
    rx_active = sync_mode & port_on & clk_from_master;
    // Overrun stalls reception until software drops continuous enable
    rx_active = rx_active & cont_enable & !halted;
  end

  always_comb begin
    rx_cond = RXS_OFF;
    if (halted) begin
      rx_cond = RXS_HALT;
    end else if (rx_active && rx.busy) begin
      rx_cond = RXS_SHIFT;
    end else if (rx_active) begin
      rx_cond = RXS_IDLE;
    end
  end

  // A register write lands only once both halves are held and no response waits
  assign wr_fire = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Clock comes only from the master; data sampled on its edge
  assign ck_rise = link_s.ck & !st_r.ck_prev;
  assign ck_fall = !link_s.ck & st_r.ck_prev;
  assign smp = rx_active
    & (st_r.baud_control[CLOCK_POLARITY_POS] ? ck_rise : ck_fall);
  assign nine = st_r.receive_status_control[NINE_BIT_RX_OPTION_POS];

  // Register read decode
  always_comb begin
    rd_hit = (s_axi_araddr[31:8] == 24'h0);
    rd_val = 8'h00;
    case (s_axi_araddr[7:0])
      OFF_INTERRUPT_CONTROL: rd_val = st_r.interrupt_control;
      OFF_IRQ_FLAGS_1: rd_val = st_r.irq_flags;
      OFF_IRQ_ENABLES_1: rd_val = st_r.irq_enables;
      OFF_IRQ_PRIORITY_1: rd_val = st_r.irq_priority;
      OFF_RECEIVE_STATUS_CONTROL: rd_val = st_r.receive_status_control;
      OFF_RECEIVE_BUFFER: rd_val = st_r.receive_buffer;
      OFF_TRANSMIT_STATUS_CONTROL: rd_val = st_r.transmit_status_control;
      OFF_BAUD_CONTROL: begin
        rd_val = st_r.baud_control;
        rd_val[RX_IDLE_POS] = (rx_cond != RXS_SHIFT);
      end
      OFF_BAUD_DIVISOR_HIGH: rd_val = st_r.baud_divisor_high;
      OFF_BAUD_DIVISOR_LOW: rd_val = st_r.baud_divisor_low;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    pend = 8'h00;
    st_nxt.ck_prev = link_s.ck;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.aw_off = s_axi_awaddr[7:0];
      st_nxt.aw_hit = (s_axi_awaddr[31:8] == 24'h0) && (s_axi_awaddr[1:0] == 2'h0);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_ok = 1'b1;
      st_nxt.w_dat = s_axi_wdata[7:0];
      // Registers sit in byte lane 0; the other lanes are ignored
      st_nxt.w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    if (wr_fire) begin
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (st_r.aw_off)
        OFF_INTERRUPT_CONTROL: begin
          if (st_r.w_lane) begin
            st_nxt.interrupt_control = st_r.w_dat;
          end
        end
        OFF_IRQ_FLAGS_1: begin
          // Write one to clear
          if (st_r.w_lane) begin
            st_nxt.irq_flags = st_r.irq_flags & ~st_r.w_dat;
          end
        end
        OFF_IRQ_ENABLES_1: begin
          if (st_r.w_lane) begin
            st_nxt.irq_enables = st_r.w_dat;
          end
        end
        OFF_IRQ_PRIORITY_1: begin
          if (st_r.w_lane) begin
            st_nxt.irq_priority = st_r.w_dat;
          end
        end
        OFF_RECEIVE_STATUS_CONTROL: begin
          if (st_r.w_lane) begin
            st_nxt.receive_status_control =
              (st_r.w_dat & RECEIVE_STATUS_CONTROL_WMASK)
              | (st_r.receive_status_control & ~RECEIVE_STATUS_CONTROL_WMASK);
            if (!st_r.w_dat[CONTINUOUS_RX_ENABLE_POS]) begin
              st_nxt.receive_status_control[OVERRUN_ERROR_FLAG_POS] = 1'b0;
              st_nxt.receive_status_control[FRAMING_ERROR_FLAG_POS] = 1'b0;
            end
          end
        end
        OFF_RECEIVE_BUFFER: begin
          st_nxt.bresp = RESP_OKAY;
        end
        OFF_TRANSMIT_STATUS_CONTROL: begin
          if (st_r.w_lane) begin
            st_nxt.transmit_status_control = st_r.w_dat;
          end
        end
        OFF_BAUD_CONTROL: begin
          if (st_r.w_lane) begin
            st_nxt.baud_control = (st_r.w_dat & BAUD_CONTROL_WMASK)
              | (st_r.baud_control & ~BAUD_CONTROL_WMASK);
          end
        end
        OFF_BAUD_DIVISOR_HIGH: begin
          if (st_r.w_lane) begin
            st_nxt.baud_divisor_high = st_r.w_dat;
          end
        end
        OFF_BAUD_DIVISOR_LOW: begin
          if (st_r.w_lane) begin
            st_nxt.baud_divisor_low = st_r.w_dat;
          end
        end
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
      if (!st_r.aw_hit) begin
        st_nxt.bresp = RESP_SLVERR;
        st_nxt.receive_status_control = st_r.receive_status_control;
        st_nxt.interrupt_control = st_r.interrupt_control;
        st_nxt.irq_flags = st_r.irq_flags;
        st_nxt.irq_enables = st_r.irq_enables;
        st_nxt.irq_priority = st_r.irq_priority;
        st_nxt.transmit_status_control = st_r.transmit_status_control;
        st_nxt.baud_control = st_r.baud_control;
        st_nxt.baud_divisor_high = st_r.baud_divisor_high;
        st_nxt.baud_divisor_low = st_r.baud_divisor_low;
      end
    end

    // Read channel; reading the buffer releases the flag
    if (s_axi_rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = {24'h0, rd_val};
      st_nxt.rresp = (rd_hit && s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      if (rd_hit && s_axi_araddr[7:0] == OFF_RECEIVE_BUFFER) begin
        st_nxt.irq_flags[RX_IRQ_POS] = 1'b0;
      end
    end

    // Word completion runs last so a set beats a same-cycle clear
    if (rx.done && rx_active) begin
      if (st_r.irq_flags[RX_IRQ_POS]) begin
        // Buffer still unread: drop the word and flag overrun
        st_nxt.receive_status_control[OVERRUN_ERROR_FLAG_POS] = 1'b1;
      end else begin
        st_nxt.receive_buffer = rx.word[7:0];
        st_nxt.receive_status_control[NINTH_RX_BIT_POS] = rx.word[8];
        st_nxt.irq_flags[RX_IRQ_POS] = 1'b1;
      end
    end

    // Interrupt and wake outputs follow the next register state
    pend = st_nxt.irq_flags & st_nxt.irq_enables;
    st_nxt.irq = (pend != 8'h00)
      & st_nxt.interrupt_control[GLOBAL_IRQ_ENABLE_POS]
      & st_nxt.interrupt_control[PERIPHERAL_IRQ_ENABLE_POS];
    st_nxt.irq_hp = st_nxt.irq & ((pend & st_nxt.irq_priority) != 8'h00);
    // Wake needs only the receive enable; clocks stay on in low power
    st_nxt.wake = low_power & (pend != 8'h00);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.transmit_status_control <= RST_TRANSMIT_STATUS_CONTROL;
      st_r.baud_control <= RST_BAUD_CONTROL;
      st_r.receive_status_control <= RST_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus handshakes
  // Ready stays low while a response waits, so one write never overtakes another
  assign s_axi_awready = !st_r.aw_ok && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_ok && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign irq = st_r.irq;
  assign irq_high_priority = st_r.irq_hp;
  assign wake = st_r.wake;
endmodule // usr_rx_top
`default_nettype wire

// [tb/usr_rx_sva.sv]
// Concurrent checks on the receiver bus and interrupt ports
`timescale 1ns/1ns
`default_nettype none
module usr_rx_sva
  import usr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Power and interrupts
  input wire logic low_power,
  input wire logic irq,
  input wire logic irq_high_priority,
  input wire logic wake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_wake_gate: assert property (!low_power [*2] |-> !wake)
    else $error("wake while awake");
  chk_prio_irq: assert property (irq_high_priority |-> irq)
    else $error("priority line without request");
endmodule // usr_rx_sva
bind usr_rx_top usr_rx_sva usr_rx_sva_inst (.*);
`default_nettype wire

// [tb/usr_link_master.sv]
// External synchronous master that clocks words into the receiver
`timescale 1ns/1ns
`default_nettype none
module usr_link_master (
  // Link pins
  output var logic link_ck,
  output var logic link_dt
);
  // Clock rests low between frames; data moves mid-low so sampling never races it
  initial begin
    link_ck = 1'h0;
    link_dt = 1'h1;
  end
  task automatic send(input logic [8:0] w, input int n, input int slow);
    #3;
    for (int i = 0; i < n; i++) begin
      link_dt = w[i];
      #40 link_ck = 1'h1;
      #(80 + slow) link_ck = 1'h0;
      #40;
    end
    link_dt = ~link_dt; // Released line shows no stale bit
  endtask
endmodule // usr_link_master
`default_nettype wire

// [tb/test_usr_rx_top.sv]
// Self-checking bench for the synchronous slave receiver
`timescale 1ns/1ns
`default_nettype none
module test_usr_rx_top
  import usr_pkg::*;
;
  logic clk = 1'h0, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic low_power, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, irq_high_priority, wake;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] cfg_t[5] = '{8'h80, 8'h90, 8'h00, 8'h10, 8'h10};
  logic [7:0] cfg_r[5] = '{8'h10, 8'h90, 8'h90, 8'h10, 8'hA0};
  logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    RST_TRANSMIT_STATUS_CONTROL, RST_BAUD_CONTROL, 8'h00, 8'h00};
  wire logic link_ck, link_dt;
  int num_errors = 0, checks_done = 0;
  int q[$];
  usr_rx_top usr_rx_top_inst (.*);
  usr_link_master usr_link_master_inst (.link_ck(link_ck), .link_dt(link_dt));
  always #4 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    s_axi_bready <= 1'h0;
    chk("bvalid", {31'h0, s_axi_bvalid}, 32'h1);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    s_axi_rready <= 1'h0;
    chk("rvalid", {31'h0, s_axi_rvalid}, 32'h1);
    chk(nm, s_axi_rdata, {24'h000000, e});
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic wait_hi(input bit use_wake);
    int n;
    n = 0;
    while ((use_wake ? wake : irq) !== 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(use_wake ? "wake" : "irq", {31'h0, use_wake ? wake : irq}, 32'h1);
  endtask
  task automatic rx(input int n, input int slow);
    seed = lfsr(seed);
    q.push_back(n == 9 ? seed[8:0] : seed[7:0]);
    usr_link_master_inst.send(seed[8:0], n, slow);
  endtask
  initial begin
    #400000;
    num_errors++;
    end_of_test;
  end
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    low_power = 1'h0;
    seed = 32'hA238EE64;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    for (int i = 0; i < 10; i++) rd("reset", 8'(4 * i), rv[i], RESP_OKAY);
    wr(8'h28, 8'h55, RESP_SLVERR);
    rd("unmapped", 8'h28, 8'h00, RESP_SLVERR);
    wr(OFF_IRQ_ENABLES_1, 8'h20, RESP_OKAY);
    wr(OFF_INTERRUPT_CONTROL, 8'hC0, RESP_OKAY);
    // Each blocked set-up must leave the flag clear
    for (int i = 0; i < 5; i++) begin
      wr(OFF_TRANSMIT_STATUS_CONTROL, cfg_t[i], RESP_OKAY);
      wr(OFF_RECEIVE_STATUS_CONTROL, cfg_r[i], RESP_OKAY);
      rx(8, 0);
      void'(q.pop_back());
      repeat (20) @(posedge clk);
      rd("blocked flag", OFF_IRQ_FLAGS_1, 8'h00, RESP_OKAY);
      chk("blocked irq", {31'h0, irq}, 32'h0);
    end
    wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h10, RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      wr(OFF_RECEIVE_STATUS_CONTROL, k < 4 ? 8'h90 : 8'hD0, RESP_OKAY);
      rx(k < 4 ? 8 : 9, k == 3 ? 200 : 0);
      wait_hi(1'b0);
      rd("flags", OFF_IRQ_FLAGS_1, 8'h20, RESP_OKAY);
      if (k >= 4) rd("ninth", OFF_RECEIVE_STATUS_CONTROL, 8'(8'hD0 | q[0][8]), RESP_OKAY);
      rd("buffer", OFF_RECEIVE_BUFFER, 8'(q.pop_front()), RESP_OKAY);
      rd("flag cleared", OFF_IRQ_FLAGS_1, 8'h00, RESP_OKAY);
      chk("irq low", {31'h0, irq}, 32'h0);
    end
    // Asleep with the peripheral enable off: wake but no request
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h90, RESP_OKAY);
    wr(OFF_INTERRUPT_CONTROL, 8'h80, RESP_OKAY);
    low_power <= 1'h1;
    rx(8, 0);
    wait_hi(1'b1);
    chk("gated irq", {31'h0, irq}, 32'h0);
    wr(OFF_INTERRUPT_CONTROL, 8'hC0, RESP_OKAY);
    wr(OFF_IRQ_PRIORITY_1, 8'h20, RESP_OKAY);
    rd("prio", OFF_IRQ_PRIORITY_1, 8'h20, RESP_OKAY);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("irq prio", {31'h0, irq_high_priority}, 32'h1);
    low_power <= 1'h0;
    wr(OFF_IRQ_FLAGS_1, 8'h20, RESP_OKAY);
    rd("w1c", OFF_IRQ_FLAGS_1, 8'h00, RESP_OKAY);
    chk("wake low", {31'h0, wake}, 32'h0);
    rd("asleep word", OFF_RECEIVE_BUFFER, 8'(q.pop_front()), RESP_OKAY);
    // Second word while flag still set overruns and is dropped
    wr(OFF_IRQ_FLAGS_1, 8'h00, RESP_OKAY);
    rx(8, 0);
    wait_hi(1'b0);
    rx(8, 0);
    void'(q.pop_back());
    repeat (20) @(posedge clk);
    rd("overrun", OFF_RECEIVE_STATUS_CONTROL, 8'h92, RESP_OKAY);
    rd("kept word", OFF_RECEIVE_BUFFER, 8'(q.pop_front()), RESP_OKAY);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h80, RESP_OKAY);
    rd("err clear", OFF_RECEIVE_STATUS_CONTROL, 8'h80, RESP_OKAY);
    wr(OFF_RECEIVE_STATUS_CONTROL, 8'h90, RESP_OKAY);
    // Resume on the rising link edge to cover the other sampling polarity
    wr(OFF_BAUD_CONTROL, 8'h10, RESP_OKAY);
    rd("polarity", OFF_BAUD_CONTROL, 8'h50, RESP_OKAY);
    rx(8, 0);
    wait_hi(1'b0);
    rd("resumed", OFF_RECEIVE_BUFFER, 8'(q.pop_front()), RESP_OKAY);
    end_of_test;
  end
endmodule // test_usr_rx_top
`default_nettype wire
